// ===== shared/fdws_pkg.sv
// Constants and types for the flash data write sequencer.
// Functional notes
// [RULE_01] A committing store idles the core until programming ends, then it resumes.
// [RULE_02] Interrupt service is held off for the whole write cycle.
// [RULE_03] Stores write flash data only with write enable and data enable both set.
// [RULE_04] Write enable cleared blocks programming of every nonvolatile space.
// [RULE_05] Data enable cleared makes the flash data space inaccessible.
// [RULE_06] Programming only clears bits; stored result is old AND new.
// [RULE_07] Page erase sets every byte of the page to FF.
// [RULE_08] Eight or sixteen pages of 64 bytes, one 64-byte page buffer.
// [RULE_09] With page load mode set a store only deposits into the buffer.
// [RULE_10] Software loads each buffer location at most once per write.
// [RULE_11] Commit is a store with load mode clear; its address picks the page.
// [RULE_12] A store with an empty buffer and load mode clear programs one byte.
// [RULE_13] The page buffer is emptied after every write operation.
// [RULE_14] Auto erase set erases the page first, then programs the buffer.
// [RULE_15] Auto erase applies to whichever nonvolatile space is targeted.
// [RULE_16] No write sequence starts while the brownout detector reports low supply.
// [RULE_17] Brownout during a write sets the abort flag until software clears it.
// [RULE_18] Write inhibit bit reads low while supply is below programming level.
// [RULE_19] Software should read write inhibit before writing when brownout reset is off.
// [RULE_20] Flash data reads always succeed regardless of brownout state.
// [RULE_21] Code select with fuse set steers pointer accesses to code or signature.
// [RULE_22] Flash data spans 0200H to 03FFH or 05FFH when mapped.
// [RULE_23] Flash data accesses use 16-bit addresses and take at least four cycles.
// [RULE_24] Busy rises at the committing store and falls when programming ends.
// [RULE_25] Unloaded buffer bytes stay FF so their stored bytes are unchanged.
package fdws_pkg;
	localparam logic [7:0] MEMCTL_INDEX = 8'h96;
	localparam logic [11:0] MEMCTL_ADDR = 12'h258;
	localparam logic [7:0] MEMCTL_RESET = 8'h00;
	localparam int BIT_CODE_SEL = 7;
	localparam int BIT_AUTO_ERASE = 6;
	localparam int BIT_PAGE_LOAD = 5;
	localparam int BIT_NV_WEN = 4;
	localparam int BIT_DATA_NV_EN = 3;
	localparam int BIT_ABORT = 2;
	localparam int BIT_WR_INH_N = 0;
	localparam logic [15:0] FLASH_DATA_SPACE_BASE = 16'h0200;
	localparam int PAGE_BYTES = 64;
	localparam int PAGES_SMALL = 8;
	localparam int ACCESS_CYC = 4;
	localparam int CLK_MHZ = 40;
	localparam int ERASE_TIME_US = 2000;
	localparam int PROG_TIME_US = 2000;
	localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam logic [7:0] BYTE_ERASED = 8'hFF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACCESS = 3'b001,
		ST_ERASE = 3'b010,
		ST_PROG = 3'b011
	} fdws_state_type;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fdws_xm_req_type;

	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} fdws_xm_rsp_type;
endpackage

// ===== rtl/fdws_top.sv
// Flash data write sequencer with APB access to the memory control register.
`timescale 1ns/10ps
module fdws_top import fdws_pkg::*; #(
	parameter int PAGES = PAGES_SMALL,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int PROG_CYCLES = PROG_CYC
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core external-move port.
	input wire fdws_xm_req_type xm_in,
	output fdws_xm_rsp_type xm_out,
	// Core control and system status.
	output logic core_idle,
	output logic irq_hold,
	output logic code_route,
	input wire logic bod_low,
	input wire logic code_fuse_en
);
	localparam int PW = $clog2(PAGES);
	localparam int NBYTES = PAGES * PAGE_BYTES;

	fdws_state_type state;
	logic [23:0] cnt;
	logic [7:0] memctl;
	logic [7:0] mem [NBYTES];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PW-1:0] page;
	logic buf_clear;
	logic buf_load;
	logic erase_done;
	logic prog_done;
	logic abort_set;
	logic apb_wr;
	logic [7:0] rd_byte;

	function automatic logic in_flash_data_space(input logic [15:0] a);
		in_flash_data_space = (a >= FLASH_DATA_SPACE_BASE) && (a < FLASH_DATA_SPACE_BASE + 16'(NBYTES));
	endfunction

	function automatic logic [PW+5:0] fidx(input logic [15:0] a);
		logic [15:0] d;
		d = a - FLASH_DATA_SPACE_BASE;
		fidx = d[PW+5:0];
	endfunction

	wire logic [15:0] acc_addr = xm_in.addr;
	wire logic iap_on = memctl[BIT_CODE_SEL] & code_fuse_en;
	wire logic fd_hit = !iap_on && memctl[BIT_DATA_NV_EN] && in_flash_data_space(acc_addr); // [RULE_05] [RULE_21] [RULE_22]
	wire logic wr_ok = fd_hit && memctl[BIT_NV_WEN]; // [RULE_03] [RULE_04]
	wire logic acc_end = (state == ST_ACCESS) && (cnt == 24'(ACCESS_CYC - 2));
	wire logic is_commit = acc_end && xm_in.we && wr_ok && !memctl[BIT_PAGE_LOAD]; // [RULE_11]
	wire logic [PW+5:0] aidx = fidx(acc_addr);

	assign apb_wr = psel && penable && pready && pwrite && (paddr == MEMCTL_ADDR);
	assign buf_load = acc_end && xm_in.we && wr_ok; // [RULE_09]
	assign erase_done = (state == ST_ERASE) && (cnt == 24'(ERASE_CYCLES - 1)) && !bod_low;
	assign prog_done = (state == ST_PROG) && (cnt == 24'(PROG_CYCLES - 1)) && !bod_low;
	assign abort_set = ((state == ST_ERASE) || (state == ST_PROG)) && bod_low; // [RULE_17]
	assign buf_clear = prog_done || abort_set || (is_commit && bod_low); // [RULE_13]
	assign rd_byte = fd_hit ? mem[aidx] : BYTE_ERASED; // [RULE_20]

	// Sequencer: access timing, then optional erase and programming.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			cnt <= '0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					cnt <= '0;
					if (xm_in.req && !xm_out.ack) begin
						state <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					cnt <= cnt + 24'd1; // [RULE_23]
					if (acc_end) begin
						cnt <= '0;
						if (is_commit && !bod_low) begin // [RULE_16]
							state <= memctl[BIT_AUTO_ERASE] ? ST_ERASE : ST_PROG; // [RULE_14]
						end else begin
							state <= ST_IDLE;
						end
					end
				end
				ST_ERASE: begin
					cnt <= cnt + 24'd1;
					if (abort_set) begin
						state <= ST_IDLE;
					end else if (erase_done) begin
						cnt <= '0;
						state <= ST_PROG;
					end
				end
				ST_PROG: begin
					cnt <= cnt + 24'd1;
					if (abort_set || prog_done) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Latch the page of the committing store.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			page <= '0;
		end else if (ce && is_commit) begin
			page <= aidx[PW+5:6]; // [RULE_11]
		end
	end

	// Page buffer; unloaded bytes hold FF so programming leaves them alone.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				pbuf[i] <= BYTE_ERASED; // [RULE_25]
			end
		end else if (ce) begin
			if (buf_clear) begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					pbuf[i] <= BYTE_ERASED; // [RULE_13]
				end
			end else if (buf_load) begin
				pbuf[aidx[5:0]] <= xm_in.wdata; // [RULE_08] [RULE_12]
			end
		end
	end

	// Nonvolatile array. It has no reset because its content outlives power cycles.
	always_ff @(posedge clk) begin
		if (ce) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (erase_done) begin
					mem[{page, 6'(i)}] <= BYTE_ERASED; // [RULE_07]
				end else if (prog_done) begin
					mem[{page, 6'(i)}] <= mem[{page, 6'(i)}] & pbuf[i]; // [RULE_06]
				end
			end
		end
	end

	// Core answer; a commit is answered when programming ends, on a brownout abort, or at access end if brownout blocks it.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			xm_out <= '0;
		end else if (ce) begin
			xm_out.ack <= (acc_end && !(is_commit && !bod_low)) || prog_done || abort_set; // [RULE_01]
			if (acc_end && !xm_in.we) begin
				xm_out.rdata <= rd_byte;
			end
		end
	end

	// Busy holds the core in idle and holds off interrupts.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			core_idle <= 1'b0;
			irq_hold <= 1'b0;
		end else if (ce) begin
			if (is_commit && !bod_low) begin
				core_idle <= 1'b1; // [RULE_24]
				irq_hold <= 1'b1; // [RULE_02]
			end else if (prog_done || abort_set) begin
				core_idle <= 1'b0; // [RULE_01] [RULE_24]
				irq_hold <= 1'b0;
			end
		end
	end

	// Memory control register; the abort set wins over a software clear.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			memctl <= MEMCTL_RESET;
		end else if (ce) begin
			if (apb_wr) begin
				memctl[7:3] <= pwdata[7:3];
				memctl[BIT_ABORT] <= pwdata[BIT_ABORT];
			end
			if (!code_fuse_en) begin
				memctl[BIT_CODE_SEL] <= 1'b0;
			end
			if (abort_set) begin
				memctl[BIT_ABORT] <= 1'b1; // [RULE_17]
			end
			memctl[1] <= 1'b0;
			memctl[BIT_WR_INH_N] <= !bod_low; // [RULE_18]
		end
	end

	// Route flag tells the core to send pointer accesses to code or signature space.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			code_route <= 1'b0;
		end else if (ce) begin
			code_route <= iap_on; // [RULE_15] [RULE_21]
		end
	end

	// APB: one wait state, then pready; unmapped addresses answer with pslverr.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (ce) begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && (paddr != MEMCTL_ADDR);
			if (psel && penable && !pready && !pwrite && (paddr == MEMCTL_ADDR)) begin
				prdata <= {24'h000000, memctl};
			end else begin
				prdata <= '0;
			end
		end
	end
endmodule

// ===== tb/fdws_sva.sv
// Checker for the flash data write sequencer ports.
`timescale 1ns/10ps
module fdws_sva import fdws_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire fdws_xm_req_type xm_in,
	input wire fdws_xm_rsp_type xm_out,
	input wire logic core_idle,
	input wire logic irq_hold,
	input wire logic code_route,
	input wire logic bod_low,
	input wire logic code_fuse_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_take;
		$rose(xm_in.req);
	endsequence
	sequence s_quiet;
		!xm_out.ack [*3];
	endsequence
	a_irq_follows_idle: assert property (irq_hold == core_idle)
		else $error("irq hold differs from core idle");
	a_busy_ends_ack: assert property ($fell(core_idle) |-> xm_out.ack)
		else $error("busy fell without acknowledge");
	a_bod_no_start: assert property ($rose(core_idle) |-> !$past(bod_low))
		else $error("write started during brownout");
	a_min_access: assert property (s_take |-> s_quiet)
		else $error("access answered too early");
	a_read_answer: assert property (s_take ##0 !xm_in.we |-> ##[3:6] xm_out.ack)
		else $error("read not answered");
	a_route_fuse: assert property (!code_fuse_en [*2] |-> !code_route)
		else $error("code route without fuse");
	a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer timing wrong");
	a_apb_unmapped: assert property (pready && paddr != MEMCTL_ADDR |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind fdws_top fdws_sva fdws_sva_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .xm_in(xm_in),
	.xm_out(xm_out), .core_idle(core_idle), .irq_hold(irq_hold), .code_route(code_route),
	.bod_low(bod_low), .code_fuse_en(code_fuse_en));

// ===== tb/fdws_core_model.sv
// Core model issuing external moves, one at a time.
`timescale 1ns/10ps
module fdws_core_model import fdws_pkg::*; (
	input wire logic clk,
	input wire fdws_xm_rsp_type xm_out,
	output fdws_xm_req_type xm_in
);
	initial xm_in = '0;
	task automatic move(input logic we, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic done);
		int n;
		n = 0;
		@(posedge clk);
		xm_in <= '{1'b1, we, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (xm_out.ack !== 1'b1 && n < 400);
		done = (xm_out.ack === 1'b1);
		rd = xm_out.rdata;
		// Released lines flip so a stale address is never mistaken for a held one.
		xm_in <= '{1'b0, 1'b0, ~a, ~d};
	endtask
endmodule

// ===== tb/flash_data_write_sequencer_tb.sv
// Self-checking bench for the flash data write sequencer.
`timescale 1ns/10ps
module flash_data_write_sequencer_tb import fdws_pkg::*;;
	logic clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	fdws_xm_req_type xm_in;
	fdws_xm_rsp_type xm_out;
	logic core_idle, irq_hold, code_route, bod_low, code_fuse_en;
	int err_count, cmp_count;
	fdws_top #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) fdws_top_inst (.clk(clk), .sys_rst(sys_rst),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xm_in(xm_in),
		.xm_out(xm_out), .core_idle(core_idle), .irq_hold(irq_hold), .code_route(code_route),
		.bod_low(bod_low), .code_fuse_en(code_fuse_en));
	fdws_core_model fdws_core_model_inst (.clk(clk), .xm_out(xm_out), .xm_in(xm_in));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
		end
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, MEMCTL_ADDR, {24'h0, d}, r);
	endtask
	task automatic rg(input logic [7:0] e);
		logic [31:0] r;
		apb(1'b0, MEMCTL_ADDR, 32'h0, r);
		chk("memory control", r, {24'h0, e});
	endtask
	task automatic st(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic ok;
		fdws_core_model_inst.move(1'b1, a, d, r, ok);
		chk("store answer", {31'h0, ok}, 32'h1);
	endtask
	task automatic ld(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic ok;
		fdws_core_model_inst.move(1'b0, a, 8'h00, r, ok);
		chk("load answer", {31'h0, ok}, 32'h1);
		chk("flash byte", {24'h0, r}, {24'h0, e});
	endtask
	task automatic final_report();
		if (err_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		err_count++;
		final_report();
	end
	initial begin
		logic [31:0] r;
		err_count = 0;
		cmp_count = 0;
		{sys_rst, ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 1'b1, 47'h0};
		{bod_low, code_fuse_en} = 2'b00;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rg(8'h01);
		apb(1'b0, 12'h004, 32'h0, r);
		chk("unmapped read", r, 32'h0);
		wr(8'hF8);
		rg(8'h79);
		code_fuse_en <= 1'b1;
		wr(8'h80);
		@(negedge clk);
		chk("code route", {31'h0, code_route}, 32'h1);
		@(posedge clk);
		code_fuse_en <= 1'b0;
		wr(8'h58);
		st(16'h0200, 8'h5A);
		ld(16'h0200, 8'h5A);
		ld(16'h0201, 8'hFF);
		wr(8'h18);
		st(16'h0200, 8'h0F);
		ld(16'h0200, 8'h0A);
		wr(8'h78);
		st(16'h0201, 8'h11);
		st(16'h023F, 8'h22);
		ld(16'h0201, 8'hFF);
		wr(8'h58);
		st(16'h0240, 8'h33);
		ld(16'h0241, 8'h11);
		ld(16'h027F, 8'h22);
		ld(16'h0242, 8'hFF);
		st(16'h0243, 8'h44);
		ld(16'h0241, 8'hFF);
		ld(16'h0243, 8'h44);
		wr(8'h08);
		st(16'h0200, 8'h00);
		ld(16'h0200, 8'h0A);
		wr(8'h10);
		ld(16'h0200, 8'hFF);
		bod_low <= 1'b1;
		wr(8'h18);
		rg(8'h18);
		st(16'h0200, 8'h00);
		ld(16'h0200, 8'h0A);
		bod_low <= 1'b0;
		wr(8'h58);
		// The supply dips while the erase is still running.
		fork
			st(16'h0203, 8'h00);
			begin
				repeat (12) @(posedge clk);
				chk("busy", {31'h0, core_idle}, 32'h1);
				chk("irq hold", {31'h0, irq_hold}, 32'h1);
				bod_low <= 1'b1;
			end
		join
		chk("busy end", {31'h0, core_idle}, 32'h0);
		rg(8'h5C);
		bod_low <= 1'b0;
		wr(8'h18);
		rg(8'h19);
		final_report();
	end
endmodule
